// ### eme_defs.svh
`ifndef EME_DEFS_SVH
`define EME_DEFS_SVH

// Leaf code that selects the measure-extend operation
`define EME_LEAF_MEASURE 8'h06
// Header tag placed in bits 63:0 of the first hashed block
`define EME_HDR_TAG 64'h00444E4554584545
// Alignment masks for the two operands
`define EME_STRUCT_ALIGN_MASK 12'hFFF
`define EME_CHUNK_ALIGN_MASK 8'hFF
// Number of 64-byte data blocks in one chunk, less one
`define EME_LAST_BLOCK 2'h3
// Counter increments per successful operation
`define EME_UPDATES_PER_OP 32'h00000005
// Highest implemented linear address bit for the canonical check
`define EME_CANON_MSB 47

// Register byte offsets
`define EME_REG_CTRL 6'h00
`define EME_REG_STATUS 6'h04
`define EME_REG_STRUCT_LO 6'h08
`define EME_REG_STRUCT_HI 6'h0C
`define EME_REG_CHUNK_LO 6'h10
`define EME_REG_CHUNK_HI 6'h14
`define EME_REG_FADDR_LO 6'h18
`define EME_REG_FADDR_HI 6'h1C
`define EME_REG_OFFS_LO 6'h20
`define EME_REG_OFFS_HI 6'h24
`define EME_REG_COUNT 6'h28
`define EME_REG_IRQ_STAT 6'h2C
`define EME_REG_IRQ_MASK 6'h30

// Field positions
`define EME_CTRL_START 0
`define EME_CTRL_LEAF_LSB 8
`define EME_IRQ_DONE 0
`define EME_IRQ_FAULT 1

// Reset values
`define EME_RST_WORD 32'h00000000
`define EME_RST_ADDR 64'h0000000000000000

`endif

// ### eme_far_model.sv
`timescale 1ns/1ps
// Lookup tables, chunk memory and hash sink beside the block
module eme_far_model #(
  parameter logic [63:0] BASE = 64'h0000000040000000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Scenario control: injected fault and slow hash engine
  input wire logic [3:0] faultSel,
  input wire logic slow,
  // Requests from the block
  input wire logic [63:0] structLinAddr,
  input wire logic [63:0] chunkLinAddr,
  input wire logic [1:0] chunkIndex,
  // Lookup answers
  output logic structInCache,
  output logic structLocked,
  output logic structInitialised,
  output logic structConflict,
  output logic measureBusy,
  output logic [63:0] structBaseAddr,
  output logic chunkInCache,
  output logic chunkMapValid,
  output logic chunkTypeOk,
  output logic [63:0] chunkOwnerAddr,
  output logic [63:0] pageEnclaveAddr,
  output logic mapBusy,
  output logic chunkConflict,
  output logic [511:0] chunkBlock,
  // Hash engine handshake
  output logic hashReady
);
  logic [2:0] stallCnt; // Stall pattern of the slow engine
  // Fault codes 2 to B each break exactly one lookup answer; structInCache is tied high
  assign structInCache = 1'b1;
  assign chunkInCache = faultSel != 4'h2;
  assign chunkMapValid = faultSel != 4'h3;
  assign chunkTypeOk = faultSel != 4'h4;
  // Owner equals the page-add structure address unless code 5
  assign chunkOwnerAddr = structLinAddr
                          ^ {51'h0, faultSel == 4'h5, 12'h0};
  assign structLocked = faultSel == 4'h6;
  assign structInitialised = faultSel == 4'h7;
  assign mapBusy = faultSel == 4'h8;
  assign chunkConflict = faultSel == 4'h9;
  assign structConflict = faultSel == 4'hA;
  assign measureBusy = faultSel == 4'hB;
  assign structBaseAddr = BASE;
  assign pageEnclaveAddr = {chunkLinAddr[63:12], 12'h000};
  // Data differs per block so order errors show
  assign chunkBlock = {16{chunkLinAddr[31:0] ^ {30'h0, chunkIndex}}};
  assign hashReady = !slow || stallCnt == 3'h0;
  // Free running stall counter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stallCnt <= 3'h0;
    end else begin
      stallCnt <= stallCnt + 3'h1;
    end
  end
endmodule : eme_far_model

// ### eme_measure_extend.sv
// Chosen here: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`include "eme_defs.svh"
module eme_measure_extend (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Avalon-MM register slave
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Interrupt
  output logic irq,
  // Processor context
  input wire logic [1:0] currentPrivilegeLevel,
  input wire logic mode64,
  input wire logic [63:0] dataSegmentBase,
  input wire logic [63:0] dataSegmentLimit,
  // Linear addresses offered for lookup
  output logic [63:0] structLinAddr,
  output logic [63:0] chunkLinAddr,
  // Lookup answers for the structure operand
  input wire logic structInCache,
  input wire logic structLocked,
  input wire logic structInitialised,
  input wire logic structConflict,
  input wire logic measureBusy,
  input wire logic [63:0] structBaseAddr,
  // Lookup answers for the chunk operand
  input wire logic chunkInCache,
  input wire logic chunkMapValid,
  input wire logic chunkTypeOk,
  input wire logic [63:0] chunkOwnerAddr,
  input wire logic [63:0] pageEnclaveAddr,
  input wire logic mapBusy,
  input wire logic chunkConflict,
  // Chunk data, one 64-byte block selected by chunkIndex
  output logic [1:0] chunkIndex,
  input wire logic [511:0] chunkBlock,
  // Blocks offered to the hash engine
  output logic [511:0] hashBlock,
  output logic hashValid,
  input wire logic hashReady,
  // Completion
  output logic opDone,
  output eme_pkg::eme_fault_t faultKind
);
  import eme_pkg::*;

  // Canonical when all bits above the implemented range match its highest bit
  function automatic logic isCanonical(input logic [63:0] a);
    isCanonical = (&a[63:`EME_CANON_MSB]) | ~(|a[63:`EME_CANON_MSB]);
  endfunction : isCanonical

  // Data segment translation; no override is possible
  function automatic logic [63:0] toLinear(input logic [63:0] ea,
                                           input logic m64,
                                           input logic [63:0] base);
    toLinear = m64 ? ea : base + ea;
  endfunction : toLinear

  eme_state_t state; // Sequencer state
  eme_state_t next_state; // Next sequencer state
  logic [63:0] structPtr; // Structure pointer operand
  logic [63:0] chunkPtr; // Chunk pointer operand
  logic [7:0] leafCode; // Leaf selected by software
  logic [63:0] faultAddr; // Address reported with a page fault
  logic [63:0] enclave_offset_field; // Offset hashed in the header
  logic [31:0] updateCount; // Measurement update counter
  logic [1:0] irqStat; // Sticky event bits
  logic [1:0] irqMask; // Interrupt enables
  logic loaded; // Current data block latched into hashBlock
  logic ack; // Bus access completes this cycle

  // Bus decode
  wire busReq = read | write;
  wire accept = busReq & ack;
  wire wrAcc = accept & write;
  wire rdAcc = accept & read;
  wire startWr = wrAcc & (address == `EME_REG_CTRL)
                 & writedata[`EME_CTRL_START];
  wire [7:0] leafWr = writedata[`EME_CTRL_LEAF_LSB +: 8];
  wire start = startWr & (state == EME_IDLE);
  wire busy = (state != EME_IDLE);
  wire readClr = rdAcc & (address == `EME_REG_IRQ_STAT);

  // Operand translation and checks, in the documented priority
  assign structLinAddr = toLinear(structPtr, mode64, dataSegmentBase);
  assign chunkLinAddr = toLinear(chunkPtr, mode64, dataSegmentBase);
  wire badLeaf = (leafCode != `EME_LEAF_MEASURE);
  wire badPriv = (currentPrivilegeLevel != 2'h0);
  wire badCanon = mode64 & (~isCanonical(structPtr)
                  | ~isCanonical(chunkPtr));
  wire badLimit = ~mode64 & ((structPtr > dataSegmentLimit)
                  | (chunkPtr > dataSegmentLimit));
  wire badStructAlign = |(structPtr[11:0] & `EME_STRUCT_ALIGN_MASK);
  wire badChunkAlign = |(chunkPtr[7:0] & `EME_CHUNK_ALIGN_MASK);
  wire gpEarly = badLeaf | badPriv | badCanon | badLimit | badStructAlign;
  wire pfStruct = ~structInCache;
  wire pfChunk = ~chunkInCache;
  wire gpMap = mapBusy | chunkConflict;
  wire pfMap = ~chunkMapValid | ~chunkTypeOk;
  // Owner match relies on software reusing the page-add address
  wire gpOwner = (chunkOwnerAddr != structLinAddr);
  wire gpStruct = structConflict | measureBusy;
  wire gpState = structLocked | structInitialised;

  // Fault selection, first failing check wins
  eme_fault_t checkFault;
  logic [63:0] checkAddr;
  always_comb begin
    checkFault = EME_FAULT_NONE;
    checkAddr = `EME_RST_ADDR;
    if (gpEarly) begin
      checkFault = EME_FAULT_GP;
    end else if (pfStruct) begin
      checkFault = EME_FAULT_PF;
      checkAddr = structLinAddr;
    end else if (badChunkAlign) begin
      checkFault = EME_FAULT_GP;
    end else if (pfChunk) begin
      checkFault = EME_FAULT_PF;
      checkAddr = chunkLinAddr;
    end else if (gpMap) begin
      checkFault = EME_FAULT_GP;
    end else if (pfMap) begin
      checkFault = EME_FAULT_PF;
      checkAddr = chunkLinAddr;
    end else if (gpOwner | gpStruct | gpState) begin
      checkFault = EME_FAULT_GP;
    end
  end

  wire checkPass = (state == EME_CHECK) & (checkFault == EME_FAULT_NONE);
  wire checkFail = (state == EME_CHECK) & (checkFault != EME_FAULT_NONE);
  wire hashTake = hashValid & hashReady;
  wire lastBlock = (chunkIndex == `EME_LAST_BLOCK);
  wire finish = (state == EME_DATA) & loaded & hashReady & lastBlock;
  // Offset of the chunk within the enclave
  wire [63:0] nextOffset = pageEnclaveAddr - structBaseAddr
                           + {52'h0, chunkLinAddr[11:0]};

  // Next state
  always_comb begin
    next_state = state;
    case (state)
      EME_IDLE: begin
        if (start) begin
          next_state = EME_CHECK;
        end
      end
      EME_CHECK: begin
        // A fault goes straight back, nothing hashed
        next_state = checkPass ? EME_HDR : EME_IDLE;
      end
      EME_HDR: begin
        if (hashReady) begin
          next_state = EME_DATA;
        end
      end
      EME_DATA: begin
        if (finish) begin
          next_state = EME_IDLE;
        end
      end
      default: begin
        next_state = EME_IDLE;
      end
    endcase
  end

  // Handshake and completion outputs
  assign hashValid = (state == EME_HDR) | ((state == EME_DATA) & loaded);
  assign waitrequest = busReq & ~ack;
  assign irq = |(irqStat & irqMask);

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= EME_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Operand and control registers, held while busy except the interrupt mask
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      structPtr <= `EME_RST_ADDR;
      chunkPtr <= `EME_RST_ADDR;
      leafCode <= 8'h00;
      irqMask <= 2'h0;
    end else if (wrAcc) begin
      case (address)
        `EME_REG_CTRL: leafCode <= busy ? leafCode : leafWr;
        `EME_REG_STRUCT_LO: structPtr[31:0] <= busy ? structPtr[31:0]
                                                    : writedata;
        `EME_REG_STRUCT_HI: structPtr[63:32] <= busy ? structPtr[63:32]
                                                     : writedata;
        `EME_REG_CHUNK_LO: chunkPtr[31:0] <= busy ? chunkPtr[31:0]
                                                  : writedata;
        `EME_REG_CHUNK_HI: chunkPtr[63:32] <= busy ? chunkPtr[63:32]
                                                   : writedata;
        `EME_REG_IRQ_MASK: irqMask <= writedata[1:0];
        default: irqMask <= irqMask;
      endcase
    end
  end

  // Fault result and offset capture
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      faultKind <= EME_FAULT_NONE;
      faultAddr <= `EME_RST_ADDR;
      enclave_offset_field <= `EME_RST_ADDR;
    end else if (state == EME_CHECK) begin
      faultKind <= checkFault;
      faultAddr <= checkAddr;
      enclave_offset_field <= checkPass ? nextOffset : enclave_offset_field;
    end
  end

  // Hash block sequencing: header first, then four chunk blocks
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hashBlock <= 512'h0;
      chunkIndex <= 2'h0;
      loaded <= 1'b0;
    end else if (checkPass) begin
      hashBlock <= {384'h0, nextOffset, `EME_HDR_TAG};
      chunkIndex <= 2'h0;
      loaded <= 1'b0;
    end else if ((state == EME_DATA) & ~loaded) begin
      hashBlock <= chunkBlock;
      loaded <= 1'b1;
    end else if ((state == EME_DATA) & hashReady) begin
      chunkIndex <= chunkIndex + 2'h1;
      loaded <= 1'b0;
    end
  end

  // Update counter: one per accepted hash block
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      updateCount <= `EME_RST_WORD;
    end else if (hashTake) begin
      updateCount <= updateCount + 32'h1;
    end
  end

  // Sticky events; a read clears only the bits it returned, set wins
  wire [1:0] events = {checkFail, finish};
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      opDone <= 1'b0;
      irqStat <= 2'h0;
    end else begin
      opDone <= finish | checkFail;
      irqStat <= (irqStat & ~(readdata[1:0] & {2{readClr}})) | events;
    end
  end

  // Read mux
  logic [31:0] rdMux;
  always_comb begin
    case (address)
      `EME_REG_CTRL: rdMux = {16'h0, leafCode, 8'h00};
      `EME_REG_STATUS: rdMux = {28'h0, faultKind, 1'b0, busy};
      `EME_REG_STRUCT_LO: rdMux = structPtr[31:0];
      `EME_REG_STRUCT_HI: rdMux = structPtr[63:32];
      `EME_REG_CHUNK_LO: rdMux = chunkPtr[31:0];
      `EME_REG_CHUNK_HI: rdMux = chunkPtr[63:32];
      `EME_REG_FADDR_LO: rdMux = faultAddr[31:0];
      `EME_REG_FADDR_HI: rdMux = faultAddr[63:32];
      `EME_REG_OFFS_LO: rdMux = enclave_offset_field[31:0];
      `EME_REG_OFFS_HI: rdMux = enclave_offset_field[63:32];
      `EME_REG_COUNT: rdMux = updateCount;
      `EME_REG_IRQ_STAT: rdMux = {30'h0, irqStat};
      `EME_REG_IRQ_MASK: rdMux = {30'h0, irqMask};
      default: rdMux = `EME_RST_WORD;
    endcase
  end

  // Bus answer: one wait cycle; read data latched in it, stands at accept
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack <= 1'b0;
      readdata <= `EME_RST_WORD;
    end else begin
      ack <= busReq & ~ack;
      readdata <= (read & ~ack) ? rdMux : readdata;
    end
  end

  // Helper: counter value at the start of hashing
  logic [31:0] countAtStart;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      countAtStart <= `EME_RST_WORD;
    end else if (checkPass) begin
      countAtStart <= updateCount;
    end
  end

  property p_leaf;
    @(posedge clk) disable iff (!rst_b)
    (state == EME_CHECK) && badLeaf |=>
      (state == EME_IDLE) && (faultKind == EME_FAULT_GP);
  endproperty
  a_leaf: assert property (p_leaf)
    else $error("wrong leaf code did not fault");

  property p_priv;
    @(posedge clk) disable iff (!rst_b)
    (state == EME_CHECK) && (currentPrivilegeLevel != 2'h0) |=>
      faultKind == EME_FAULT_GP;
  endproperty
  a_priv: assert property (p_priv)
    else $error("nonzero privilege did not fault");

  property p_struct_align;
    @(posedge clk) disable iff (!rst_b)
    (state == EME_CHECK) && (structPtr[11:0] != 12'h000) |=>
      faultKind == EME_FAULT_GP;
  endproperty
  a_struct_align: assert property (p_struct_align)
    else $error("misaligned structure pointer accepted");

  property p_chunk_align;
    @(posedge clk) disable iff (!rst_b)
    (state == EME_CHECK) && (chunkPtr[7:0] != 8'h00) |=>
      faultKind != EME_FAULT_NONE;
  endproperty
  a_chunk_align: assert property (p_chunk_align)
    else $error("misaligned chunk pointer accepted");

  property p_abort;
    @(posedge clk) disable iff (!rst_b)
    checkFail |=> !hashValid && (updateCount == $past(updateCount));
  endproperty
  a_abort: assert property (p_abort)
    else $error("faulted operation touched the measurement");

  property p_header;
    @(posedge clk) disable iff (!rst_b)
    (state == EME_HDR) |-> (hashBlock[63:0] == `EME_HDR_TAG)
      && (hashBlock[127:64] == enclave_offset_field)
      && (hashBlock[511:128] == 384'h0);
  endproperty
  a_header: assert property (p_header)
    else $error("header block malformed");

  property p_chunk_load;
    @(posedge clk) disable iff (!rst_b)
    (state == EME_DATA) && !loaded |=>
      (hashBlock == $past(chunkBlock))
      && (chunkIndex == $past(chunkIndex)) && hashValid;
  endproperty
  a_chunk_load: assert property (p_chunk_load)
    else $error("chunk block not presented in order");

  property p_count5;
    @(posedge clk) disable iff (!rst_b)
    $rose(opDone) && (faultKind == EME_FAULT_NONE) |->
      updateCount == countAtStart + `EME_UPDATES_PER_OP;
  endproperty
  a_count5: assert property (p_count5)
    else $error("update counter did not rise by five");

endmodule : eme_measure_extend

// ### eme_measure_extend_tb_top.sv
`timescale 1ns/1ps
`include "eme_defs.svh"
// Self-checking bench for the measure-extend block
module eme_measure_extend_tb_top;
  import eme_pkg::*;
  localparam logic [63:0] BASE = 64'h0000000040000000;
  // Bench drive
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [5:0] address = 6'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic [1:0] current_privilege_level = 2'h0;
  logic mode = 1'b1;
  logic [63:0] lim = 64'hFFFFFFFFFFFFFFFF;
  logic [3:0] fSel = 4'h0;
  logic slow = 1'b0;
  // Block outputs and lookup wiring
  logic [31:0] readdata;
  logic waitrequest, irq, opDone, hashValid, hashReady;
  logic [63:0] sLin, cLin, sBase, cOwn, pAddr;
  logic [1:0] cIdx;
  logic [511:0] cBlk, hashBlock;
  eme_fault_t faultKind;
  logic sIn, sLk, sInit, sCf, mBusy, cIn, cVal, cTyp, mpBusy, cCf;
  // Expectation notes and counters
  logic [511:0] expBlk[$];
  logic [1:0] expFlt[$];
  int n_fail = 0;
  int checks_done = 0;
  logic [31:0] q;
  logic [63:0] sp, cp;
  logic [63:0] segBase = 64'h0;

  always #25 clk = ~clk;

  eme_measure_extend u_dut (.clk(clk), .rst_b(rst_b), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .irq(irq), .currentPrivilegeLevel(current_privilege_level),
    .mode64(mode), .dataSegmentBase(segBase), .dataSegmentLimit(lim),
    .structLinAddr(sLin), .chunkLinAddr(cLin), .structInCache(sIn),
    .structLocked(sLk), .structInitialised(sInit), .structConflict(sCf),
    .measureBusy(mBusy), .structBaseAddr(sBase), .chunkInCache(cIn),
    .chunkMapValid(cVal), .chunkTypeOk(cTyp), .chunkOwnerAddr(cOwn),
    .pageEnclaveAddr(pAddr), .mapBusy(mpBusy), .chunkConflict(cCf),
    .chunkIndex(cIdx), .chunkBlock(cBlk), .hashBlock(hashBlock),
    .hashValid(hashValid), .hashReady(hashReady), .opDone(opDone),
    .faultKind(faultKind));

  eme_far_model #(.BASE(BASE)) u_far (.clk(clk), .rst_b(rst_b),
    .faultSel(fSel), .slow(slow), .structLinAddr(sLin), .chunkLinAddr(cLin),
    .chunkIndex(cIdx), .structInCache(sIn), .structLocked(sLk),
    .structInitialised(sInit), .structConflict(sCf), .measureBusy(mBusy),
    .structBaseAddr(sBase), .chunkInCache(cIn), .chunkMapValid(cVal),
    .chunkTypeOk(cTyp), .chunkOwnerAddr(cOwn), .pageEnclaveAddr(pAddr),
    .mapBusy(mpBusy), .chunkConflict(cCf), .chunkBlock(cBlk),
    .hashReady(hashReady));

  // Verdict and end of run
  task automatic wrap_up();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up

  // One comparison
  task automatic chk(input string nm, input logic [511:0] e,
                     input logic [511:0] g);
    checks_done++;
    if (g !== e) begin
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
      n_fail++;
    end
  endtask : chk

  // Avalon access held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int i;
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (waitrequest !== 1'b0 && i < 50);
    r = readdata;
    write <= 1'b0;
    read <= 1'b0;
    if (i >= 50) begin
      n_fail++;
      wrap_up();
    end
    @(posedge clk);
  endtask : bus

  // Load operands, start, note expectations, wait for completion
  task automatic run_op(input logic [7:0] leaf, input logic [1:0] pl,
    input logic m, input logic [63:0] s, input logic [63:0] c,
    input logic [3:0] fs, input eme_fault_t ef);
    int i;
    logic [63:0] lin;
    current_privilege_level <= pl;
    mode <= m;
    fSel <= fs;
    bus(1'b1, `EME_REG_STRUCT_LO, s[31:0], q);
    bus(1'b1, `EME_REG_STRUCT_HI, s[63:32], q);
    bus(1'b1, `EME_REG_CHUNK_LO, c[31:0], q);
    bus(1'b1, `EME_REG_CHUNK_HI, c[63:32], q);
    // Segment base applies outside 64-bit mode only
    lin = m ? c : c + segBase;
    expFlt.push_back(ef);
    if (ef == EME_FAULT_NONE) begin
      expBlk.push_back({384'h0, lin - BASE, `EME_HDR_TAG});
      for (int k = 0; k < 4; k++) begin
        expBlk.push_back({16{lin[31:0] ^ 32'(k)}});
      end
    end
    bus(1'b1, `EME_REG_CTRL, {16'h0, leaf, 8'h01}, q);
    i = 0;
    while (opDone !== 1'b1 && i < 100) begin
      @(posedge clk);
      i++;
    end
    if (i >= 100) begin
      n_fail++;
      wrap_up();
    end
    @(posedge clk);
    chk("blocks left", 512'h0, 512'(expBlk.size()));
  endtask : run_op

  // Watcher: takes the oldest note whenever a result appears
  always @(posedge clk) begin
    if (hashValid === 1'b1 && hashReady === 1'b1) begin
      chk("hashBlock", expBlk.size() ? expBlk.pop_front() : ~hashBlock,
          hashBlock);
    end
    if (opDone === 1'b1) begin
      chk("faultKind", expFlt.size() ? expFlt.pop_front() : ~faultKind,
          faultKind);
    end
  end

  // Main sequence
  initial begin
    void'($urandom(32'hF41CB866));
    sp = {32'h0, 4'h1, 16'($urandom()), 12'h000};
    cp = {32'h0, 4'h5, 20'($urandom()), 8'h00};
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    bus(1'b0, `EME_REG_COUNT, 32'h0, q);
    chk("count", 512'h0, q);
    bus(1'b0, 6'h3C, 32'h0, q);
    chk("unmapped", 512'h0, q);
    // Every lookup fault except the structure page fault, then operand faults
    for (int f = 2; f < 12; f++) begin
      run_op(8'h06, 2'h0, 1'b1, sp, cp, 4'(f),
        f < 5 ? EME_FAULT_PF : EME_FAULT_GP);
    end
    // Page fault on the chunk reports the chunk address
    run_op(8'h06, 2'h0, 1'b1, sp, cp, 4'h2, EME_FAULT_PF);
    bus(1'b0, `EME_REG_FADDR_LO, 32'h0, q);
    chk("fault address", 512'(cp[31:0]), q);
    run_op(8'h06, 2'h1, 1'b1, sp, cp, 4'h0, EME_FAULT_GP);
    run_op(8'h07, 2'h0, 1'b1, sp, cp, 4'h0, EME_FAULT_GP);
    run_op(8'h06, 2'h0, 1'b1, sp | 64'h800, cp, 4'h0, EME_FAULT_GP);
    run_op(8'h06, 2'h0, 1'b1, sp, cp | 64'h80, 4'h0, EME_FAULT_GP);
    run_op(8'h06, 2'h0, 1'b1, sp | 64'h0000800000000000, cp, 4'h0,
      EME_FAULT_GP);
    run_op(8'h06, 2'h0, 1'b1, sp, cp | 64'h8000000000000000, 4'h0,
      EME_FAULT_GP);
    lim <= 64'h0000000000000FFF;
    run_op(8'h06, 2'h0, 1'b0, sp, cp, 4'h0, EME_FAULT_GP);
    lim <= 64'hFFFFFFFFFFFFFFFF;
    bus(1'b0, `EME_REG_COUNT, 32'h0, q);
    chk("count", 512'h0, q);
    bus(1'b0, `EME_REG_IRQ_STAT, 32'h0, q);
    chk("irq status", 512'h2, q);
    // Success, then interrupt mask and clear
    run_op(8'h06, 2'h0, 1'b1, sp, cp, 4'h0, EME_FAULT_NONE);
    bus(1'b0, `EME_REG_OFFS_LO, 32'h0, q);
    chk("offset", 512'((cp - BASE) & 64'hFFFFFFFF), q);
    bus(1'b0, `EME_REG_COUNT, 32'h0, q);
    chk("count", 512'h5, q);
    chk("irq masked", 512'h0, irq);
    bus(1'b1, `EME_REG_IRQ_MASK, 32'h3, q);
    chk("irq", 512'h1, irq);
    bus(1'b0, `EME_REG_IRQ_STAT, 32'h0, q);
    chk("irq status", 512'h1, q);
    chk("irq cleared", 512'h0, irq);
    // Second pass: stalling engine, 32-bit mode, nonzero segment base
    slow <= 1'b1;
    segBase <= 64'h0000000001000000;
    run_op(8'h06, 2'h0, 1'b0, sp, cp + 64'h100, 4'h0, EME_FAULT_NONE);
    bus(1'b0, `EME_REG_COUNT, 32'h0, q);
    chk("count", 512'hA, q);
    wrap_up();
  end
endmodule : eme_measure_extend_tb_top

// ### eme_pkg.sv
package eme_pkg;

  // Sequencer states, Gray coded along idle, check, header, data
  typedef enum logic [1:0] {
    EME_IDLE = 2'b00,
    EME_CHECK = 2'b01,
    EME_HDR = 2'b11,
    EME_DATA = 2'b10
  } eme_state_t;

  // Fault reported at the end of operand checking
  typedef enum logic [1:0] {
    EME_FAULT_NONE = 2'b00,
    EME_FAULT_GP = 2'b01,
    EME_FAULT_PF = 2'b10
  } eme_fault_t;

endpackage : eme_pkg
